/* src/apt_pair_trig.sv */
// apt_pair_trig: trigger selection, pending flags and interrupts for five conversion pairs
// Behaviour
// - selector code zero disables the pair
// - code 00001 uses the pair's kick bit
// - code 00010 uses the shared global trigger
// - codes 00011/01101 pick special event triggers
// - codes 00100-01011 pick primary triggers 1-8
// - code 01100 picks the timer one match
// - codes 01110-10110 pick secondary triggers 1-9
// - codes 10111-11110 pick current-limit triggers 1-8
// - code 11111 picks the timer two match
// - trigger sets awaiting, completion clears it
// - interrupt enable gates completion interrupt request
// - kick starts software conversion, clears when awaiting
// - pairs 4,6,7,9 map to inputs 8,12,14,18
// - two pairs per 16-bit control register; here pair 4 sits alone in the low byte of its register
// - pair 8 maps to 16/17, kick cleared
//
// The implementer's own choices: strobed register access and the placing of the registers.
`timescale 1ns/100ps

module apt_pair_trig (
   input  wire logic        ref_clk_in,        // 250 MHz system clock
   input  wire logic        resetn_in,         // asynchronous power-on reset, active low
   input  wire logic [2:0]  addr_in,           // register word address
   input  wire logic [15:0] wr_data_in,        // write data
   input  wire logic        wr_strobe_in,      // one-cycle write strobe
   input  wire logic        rd_strobe_in,      // one-cycle read strobe
   output logic      [15:0] rd_data_out,       // read data, the cycle after the strobe
   output logic             irq_out,           // level interrupt
   input  wire logic [7:0]  pwm_pri_trig_in,   // primary triggers, generator 1 at bit 0
   input  wire logic [8:0]  pwm_sec_trig_in,   // secondary triggers, generator 1 at bit 0
   input  wire logic [7:0]  pwm_clim_trig_in,  // current-limit triggers, generator 1 at bit 0
   input  wire logic        pwm_sevt_in,       // primary special event trigger
   input  wire logic        pwm_sec_sevt_in,   // secondary special event trigger
   input  wire logic        tmr1_match_in,     // timer one period match
   input  wire logic        tmr2_match_in,     // timer two period match
   input  wire logic [4:0]  conv_done_in,      // core finished the pair, one pulse per pair
   output logic             conv_req_out,      // one-cycle request to the core
   output logic      [4:0]  conv_chan_out,     // even analog input of the requested pair
   output logic      [2:0]  conv_pair_out      // pair index of the request
);

   apt_pkg::apt_state_t s_r;    // registered state
   apt_pkg::apt_state_t s_nxt;  // next state

   // pick the one trigger bit that a selector code names
   function automatic logic sel_trig(input logic [4:0] code, input logic kick, input logic glob);
      logic [4:0] off;
      logic       hit;
      off = 5'h00;
      hit = 1'b0;
      // a plain compare chain, so every nonzero code maps to exactly one input
      // zero code selects nothing
      if (code == apt_pkg::SRC_OFF) begin
         hit = 1'b0;
      end else if (code == apt_pkg::SRC_INDIV) begin
         hit = kick;
      end else if (code == apt_pkg::SRC_GLOBAL) begin
         hit = glob;
      end else if (code == apt_pkg::SRC_SEVT) begin
         hit = pwm_sevt_in;
      end else if (code == apt_pkg::SRC_SEC_SEVT) begin
         hit = pwm_sec_sevt_in;
      end else if (code >= apt_pkg::SRC_PRI_FIRST && code <= apt_pkg::SRC_PRI_LAST) begin
         off = code - apt_pkg::SRC_PRI_FIRST;
         hit = pwm_pri_trig_in[off[2:0]];
      end else if (code == apt_pkg::SRC_TMR1) begin
         hit = tmr1_match_in;
      end else if (code >= apt_pkg::SRC_SEC_FIRST && code <= apt_pkg::SRC_SEC_LAST) begin
         off = code - apt_pkg::SRC_SEC_FIRST;
         hit = pwm_sec_trig_in[off[3:0]];
      end else if (code >= apt_pkg::SRC_CLIM_FIRST && code <= apt_pkg::SRC_CLIM_LAST) begin
         off = code - apt_pkg::SRC_CLIM_FIRST;
         hit = pwm_clim_trig_in[off[2:0]];
      end else begin
         hit = tmr2_match_in;
      end
      return hit;
   endfunction : sel_trig

   // next-state logic: bus writes, trigger capture, completion, arbitration, reads
   always_comb begin
      logic       trig;      // selected trigger fired for this pair
      logic       done;      // completion for a pair really awaiting
      logic       found;     // arbiter already picked a pair
      logic [7:0] half;      // byte of the pair inside its register
      trig  = 1'b0;
      done  = 1'b0;
      found = 1'b0;
      half  = 8'h00;
      s_nxt = s_r;
      // pulses and the read answer last one cycle only
      s_nxt.rd_data = 16'h0000;
      s_nxt.req     = 1'b0;
      s_nxt.glob    = 1'b0;

      // clear first so that a same-cycle completion still lands
      // a completion and a clear in one cycle leave the status bit set
      if (wr_strobe_in && addr_in == apt_pkg::REG_INT_CLEAR) begin
         s_nxt.stat = s_r.stat & ~wr_data_in[4:0];
      end

      for (int i = 0; i < apt_pkg::NUM_PAIRS; i++) begin
         // each pulse seen once, flag set is idempotent
         trig = sel_trig(s_r.src[i], s_r.kick[i], s_r.glob);
         done = conv_done_in[i] & s_r.await[i];
         if (done) begin
            s_nxt.await[i]  = 1'b0;
            s_nxt.issued[i] = 1'b0;
            if (s_r.ien[i]) begin
               s_nxt.stat[i] = 1'b1;
            end
         end
         // trigger sets awaiting, wins over completion
         if (trig) begin
            s_nxt.await[i] = 1'b1;
         end
         if (s_nxt.await[i]) begin
            s_nxt.kick[i] = 1'b0;
         end
      end

      // lowest pair index wins; a pair already handed over waits for its completion
      // the core must answer every request with one done, or that pair stalls for good
      for (int i = apt_pkg::NUM_PAIRS - 1; i >= 0; i--) begin
         if (s_r.await[i] && !s_r.issued[i] && !conv_done_in[i]) begin
            found = 1'b1;
            s_nxt.pair = 3'(i);
            // even input of pairs 4, 6, 7, 9
            // pair 8 uses inputs 16 and 17
            s_nxt.chan = apt_pkg::PAIR_EVEN_CHAN[i];
         end
      end
      if (found) begin
         s_nxt.req               = 1'b1;
         s_nxt.issued[s_nxt.pair] = 1'b1;
      end

      // control register writes; software kick beats the hardware clear above
      // a kick written while the pair awaits is cleared the next cycle and is lost unless completion lands in that cycle
      for (int i = 0; i < apt_pkg::NUM_PAIRS; i++) begin
         if (wr_strobe_in && addr_in == apt_pkg::PAIR_REG[i]) begin
            // odd pair in the upper byte
            half = apt_pkg::PAIR_HIGH[i] ? wr_data_in[15:8] : wr_data_in[7:0];
            s_nxt.ien[i]  = half[apt_pkg::FLD_INT_EN];
            s_nxt.kick[i] = half[apt_pkg::FLD_KICK];
            s_nxt.src[i]  = half[apt_pkg::FLD_SRC_HI:0];
            // awaiting flag belongs to hardware, the written bit is dropped
         end
      end
      if (wr_strobe_in && addr_in == apt_pkg::REG_INT_ENABLE) begin
         s_nxt.ena = wr_data_in[4:0];
      end
      // global kick reaches every pair one cycle after the write
      if (wr_strobe_in && addr_in == apt_pkg::REG_GLOBAL_KICK) begin
         s_nxt.glob = wr_data_in[0];
      end

      // level interrupt from enabled sticky bits
      s_nxt.irq = |(s_nxt.stat & s_nxt.ena);

      // reads show the registered state; unmapped words read zero
      // the clear and global kick words are write only and read zero as well
      if (rd_strobe_in) begin
         for (int i = 0; i < apt_pkg::NUM_PAIRS; i++) begin
            if (addr_in == apt_pkg::PAIR_REG[i]) begin
               half = {s_r.ien[i], s_r.await[i], s_r.kick[i], s_r.src[i]};
               if (apt_pkg::PAIR_HIGH[i]) begin
                  s_nxt.rd_data[15:8] = half;
               end else begin
                  s_nxt.rd_data[7:0] = half;
               end
            end
         end
         if (addr_in == apt_pkg::REG_INT_STATUS) begin
            s_nxt.rd_data[4:0] = s_r.stat;
         end else if (addr_in == apt_pkg::REG_INT_ENABLE) begin
            s_nxt.rd_data[4:0] = s_r.ena;
         end
      end
   end

   // state register
   // one register for the whole state keeps every field on the same reset
   always_ff @(posedge ref_clk_in or negedge resetn_in) begin
      if (!resetn_in) begin
         s_r <= '0;
      end else begin
         s_r <= s_nxt;
      end
   end

   // outputs straight from flip-flops
   // no logic after the register, so the core sees clean single-cycle pulses
   assign rd_data_out   = s_r.rd_data;
   assign irq_out       = s_r.irq;
   assign conv_req_out  = s_r.req;
   assign conv_chan_out = s_r.chan;
   assign conv_pair_out = s_r.pair;

   // checks below watch the registered state; pair 0 carries most of them
   // because its selector is the one swept through codes 0 and 3 to 31
   default clocking cb @(posedge ref_clk_in);
   endclocking
   default disable iff (!resetn_in);

   property p_off_never_rises;
      $rose(s_r.await[1]) |-> $past(s_r.src[1]) != apt_pkg::SRC_OFF;
   endproperty
   a_off_never_rises: assert property (p_off_never_rises) else $error("awaiting rose with selector off");

   property p_kick_starts;
      (s_r.src[0] == apt_pkg::SRC_INDIV && s_r.kick[0]) |=> s_r.await[0];
   endproperty
   a_kick_starts: assert property (p_kick_starts) else $error("kick did not set awaiting");

   property p_global_starts;
      (s_r.src[3] == apt_pkg::SRC_GLOBAL && s_r.glob) |=> s_r.await[3];
   endproperty
   a_global_starts: assert property (p_global_starts) else $error("global kick ignored");

   property p_sevt_starts;
      (s_r.src[0] == apt_pkg::SRC_SEC_SEVT && pwm_sec_sevt_in) |=> s_r.await[0];
   endproperty
   a_sevt_starts: assert property (p_sevt_starts) else $error("secondary special event ignored");

   property p_pri_order;
      (s_r.src[0] == 5'h06 && pwm_pri_trig_in[2]) |=> s_r.await[0];
   endproperty
   a_pri_order: assert property (p_pri_order) else $error("primary trigger three ignored");

   property p_tmr1;
      (s_r.src[0] == apt_pkg::SRC_TMR1 && tmr1_match_in) |=> s_r.await[0];
   endproperty
   a_tmr1: assert property (p_tmr1) else $error("timer one match ignored");

   property p_sec_last;
      (s_r.src[0] == apt_pkg::SRC_SEC_LAST && pwm_sec_trig_in[8]) |=> s_r.await[0];
   endproperty
   a_sec_last: assert property (p_sec_last) else $error("secondary trigger nine ignored");

   property p_clim_last;
      (s_r.src[0] == apt_pkg::SRC_CLIM_LAST && pwm_clim_trig_in[7]) |=> s_r.await[0];
   endproperty
   a_clim_last: assert property (p_clim_last) else $error("current-limit trigger eight ignored");

   property p_tmr2;
      (s_r.src[0] == apt_pkg::SRC_TMR2 && tmr2_match_in) |=> s_r.await[0];
   endproperty
   a_tmr2: assert property (p_tmr2) else $error("timer two match ignored");

   property p_done_clears;
      (conv_done_in[0] && s_r.await[0] && s_r.src[0] == apt_pkg::SRC_INDIV && !s_r.kick[0]) |=> !s_r.await[0];
   endproperty
   a_done_clears: assert property (p_done_clears) else $error("completion left awaiting set");

   property p_irq_path;
      (conv_done_in[0] && s_r.await[0] && s_r.ien[0]) |=> s_r.stat[0];
   endproperty
   a_irq_path: assert property (p_irq_path) else $error("enabled completion gave no interrupt");

   property p_no_stat_disabled;
      $rose(s_r.stat[0]) |-> $past(s_r.ien[0]) && $past(conv_done_in[0]);
   endproperty
   a_no_stat_disabled: assert property (p_no_stat_disabled) else $error("status set without enable");

   property p_kick_clear;
      ($rose(s_r.await[3]) && !$past(wr_strobe_in)) |-> !s_r.kick[3];
   endproperty
   a_kick_clear: assert property (p_kick_clear) else $error("kick not cleared by awaiting");

   property p_chan_map;
      (conv_req_out && conv_pair_out == 3'h4) |-> conv_chan_out == 5'h12;
   endproperty
   a_chan_map: assert property (p_chan_map) else $error("pair nine mapped to wrong input");

   property p_layout;
      (rd_strobe_in && addr_in == apt_pkg::REG_CTRL_SIX_SEVEN)
         |=> rd_data_out == {$past(s_r.ien[2]), $past(s_r.await[2]), $past(s_r.kick[2]), $past(s_r.src[2]),
                             $past(s_r.ien[1]), $past(s_r.await[1]), $past(s_r.kick[1]), $past(s_r.src[1])};
   endproperty
   a_layout: assert property (p_layout) else $error("control register layout wrong");

   property p_rd_idle;
      !$past(rd_strobe_in) |-> rd_data_out == 16'h0000;
   endproperty
   a_rd_idle: assert property (p_rd_idle) else $error("read data stood outside its cycle");

   property p_no_reissue;
      (conv_req_out && conv_pair_out == 3'h0) |=> !(conv_req_out && conv_pair_out == 3'h0);
   endproperty
   a_no_reissue: assert property (p_no_reissue) else $error("pair requested twice in a row");

   property p_stat_sticky;
      (s_r.stat[0] && !(wr_strobe_in && addr_in == apt_pkg::REG_INT_CLEAR)) |=> s_r.stat[0];
   endproperty
   a_stat_sticky: assert property (p_stat_sticky) else $error("status dropped without a clear");

   property p_irq_level;
      (s_r.stat[0] && s_r.ena[0]) |-> irq_out;
   endproperty
   a_irq_level: assert property (p_irq_level) else $error("enabled status without interrupt");

   property p_await_holds;
      (s_r.await[0] && !conv_done_in[0]) |=> s_r.await[0];
   endproperty
   a_await_holds: assert property (p_await_holds) else $error("awaiting dropped without completion");

   property p_req_follows;
      ($rose(s_r.await[0]) && !conv_done_in[0]) |=> conv_req_out && conv_pair_out == 3'h0;
   endproperty
   a_req_follows: assert property (p_req_follows) else $error("awaiting pair not requested");

   property p_off_quiet;
      (s_r.src[0] == apt_pkg::SRC_OFF && !s_r.await[0]) |=> !s_r.await[0];
   endproperty
   a_off_quiet: assert property (p_off_quiet) else $error("disabled pair started awaiting");

   property p_kick_write;
      (wr_strobe_in && addr_in == apt_pkg::REG_CTRL_FOUR && wr_data_in[apt_pkg::FLD_KICK]) |=> s_r.kick[0];
   endproperty
   a_kick_write: assert property (p_kick_write) else $error("written kick did not stick");

   property p_await_hw_only;
      (wr_strobe_in && addr_in == apt_pkg::REG_CTRL_FOUR && wr_data_in[apt_pkg::FLD_AWAIT] && !s_r.await[0]
         && s_r.src[0] == apt_pkg::SRC_INDIV && !s_r.kick[0]) |=> !s_r.await[0];
   endproperty
   a_await_hw_only: assert property (p_await_hw_only) else $error("software set the awaiting flag");

   property p_chan_eight;
      (conv_req_out && conv_pair_out == 3'h3) |-> conv_chan_out == 5'h10;
   endproperty
   a_chan_eight: assert property (p_chan_eight) else $error("pair eight mapped to wrong input");

endmodule : apt_pair_trig

/* src/apt_pkg.sv */
// apt_pkg: constants and types for the conversion pair trigger control block
package apt_pkg;

   // number of conversion pairs handled here (pairs 4, 6, 7, 8, 9)
   localparam int          NUM_PAIRS   = 5;
   localparam int          ADDR_W      = 3;
   localparam int          DATA_W      = 16;
   localparam int          SRC_W       = 5;

   // register word offsets on the plain register port
   localparam logic [2:0]  REG_CTRL_FOUR       = 3'h0;  // pair 4 in low byte
   localparam logic [2:0]  REG_CTRL_SIX_SEVEN  = 3'h1;  // pair_ctrl_six_seven
   localparam logic [2:0]  REG_CTRL_EIGHT_NINE = 3'h2;  // pair_ctrl_eight_nine
   localparam logic [2:0]  REG_INT_STATUS      = 3'h3;  // sticky completion status, read only
   localparam logic [2:0]  REG_INT_CLEAR       = 3'h4;  // write one to clear, reads zero
   localparam logic [2:0]  REG_INT_ENABLE      = 3'h5;  // gates status onto the irq output
   localparam logic [2:0]  REG_GLOBAL_KICK     = 3'h6;  // bit 0 fires the global software trigger

   // reset values
   localparam logic [15:0] CTRL_RESET          = 16'h0000;
   localparam logic [4:0]  MASK_RESET          = 5'h00;

   // field positions inside one 8-bit pair half
   localparam int          FLD_INT_EN  = 7;
   localparam int          FLD_AWAIT   = 6;
   localparam int          FLD_KICK    = 5;
   localparam int          FLD_SRC_HI  = 4;
   localparam int          FLD_HI_BYTE = 8;  // odd pair sits this far up

   // trigger source selector codes
   localparam logic [4:0]  SRC_OFF       = 5'h00;
   localparam logic [4:0]  SRC_INDIV     = 5'h01;
   localparam logic [4:0]  SRC_GLOBAL    = 5'h02;
   localparam logic [4:0]  SRC_SEVT      = 5'h03;
   localparam logic [4:0]  SRC_PRI_FIRST = 5'h04;
   localparam logic [4:0]  SRC_PRI_LAST  = 5'h0B;
   localparam logic [4:0]  SRC_TMR1      = 5'h0C;
   localparam logic [4:0]  SRC_SEC_SEVT  = 5'h0D;
   localparam logic [4:0]  SRC_SEC_FIRST = 5'h0E;
   localparam logic [4:0]  SRC_SEC_LAST  = 5'h16;
   localparam logic [4:0]  SRC_CLIM_FIRST = 5'h17;
   localparam logic [4:0]  SRC_CLIM_LAST = 5'h1E;
   localparam logic [4:0]  SRC_TMR2      = 5'h1F;

   // per pair index: register, half, even analog input (odd input is one above)
   localparam logic [4:0][2:0] PAIR_REG  = {REG_CTRL_EIGHT_NINE, REG_CTRL_EIGHT_NINE,
                                            REG_CTRL_SIX_SEVEN, REG_CTRL_SIX_SEVEN, REG_CTRL_FOUR};
   localparam logic [4:0]      PAIR_HIGH = 5'h14;
   localparam logic [4:0][4:0] PAIR_EVEN_CHAN = {5'h12, 5'h10, 5'h0E, 5'h0C, 5'h08};

   // whole block state, registered in one place
   typedef struct packed {
      logic [4:0][4:0] src;      // trigger source selectors
      logic [4:0]      ien;      // per pair interrupt request enable
      logic [4:0]      await;    // awaiting conversion flags
      logic [4:0]      kick;     // software kick bits
      logic [4:0]      issued;   // request already handed to the core
      logic [4:0]      stat;     // sticky completion status
      logic [4:0]      ena;      // interrupt output enable
      logic            glob;     // global software trigger pulse
      logic [15:0]     rd_data;  // read answer
      logic            irq;      // interrupt output
      logic            req;      // conversion request pulse
      logic [4:0]      chan;     // even input of requested pair
      logic [2:0]      pair;     // index of requested pair
   } apt_state_t;

endpackage : apt_pkg

/* testbench/apt_core_model.sv */
// apt_core_model: behavioural conversion core answering each request after a set delay
`timescale 1ns/100ps

module apt_core_model (
   input  wire logic       ref_clk_in,    // system clock
   input  wire logic       conv_req_in,   // request pulse from the block
   input  wire logic [2:0] conv_pair_in,  // pair index of the request
   input  wire logic [7:0] lat_in,        // cycles from request to done
   output logic      [4:0] conv_done_out  // one done pulse per request
);
   int         cnt [5];             // cycles left per pair, zero when idle
   logic [4:0] done_r = 5'h00;      // quiet at time zero

   assign conv_done_out = done_r;

   // count down each pair; a long delay stands in for a slow core
   always @(posedge ref_clk_in) begin
      done_r <= 5'h00;
      for (int i = 0; i < 5; i++) begin
         if (cnt[i] == 1) begin
            done_r[i] <= 1'b1;
         end
         if (cnt[i] > 0) begin
            cnt[i] <= cnt[i] - 1;
         end
      end
      // one done per request, never without one
      if (conv_req_in) begin
         cnt[conv_pair_in] <= int'(lat_in);
      end
   end
endmodule : apt_core_model

/* testbench/apt_pair_trig_tb.sv */
// apt_pair_trig_tb: self-checking bench for the conversion pair trigger control block
`timescale 1ns/100ps

module apt_pair_trig_tb;
   logic        clk        = 1'b0;      // 250 MHz system clock
   logic        resetn     = 1'b0;      // power-on reset, active low
   logic [2:0]  addr       = 3'h0;      // register word address
   logic [15:0] wdata      = 16'h0000;  // write data
   logic        wr         = 1'b0;      // write strobe
   logic        rd         = 1'b0;      // read strobe
   logic [28:0] trig       = 29'h0;     // hardware triggers, bit n answers code n+3
   logic [7:0]  lat        = 8'h02;     // core answer delay
   wire  [15:0] rdata;                  // read data
   wire         irq;                    // interrupt level
   wire         req;                    // request to the core
   wire  [4:0]  chan;                   // even input of request
   wire  [2:0]  pair;                   // pair index of request
   wire  [4:0]  done;                   // completion pulses
   int          fail_count = 0;         // mismatches
   int          n_compared = 0;         // comparisons made
   int          n_req      = 0;         // requests seen

   always #2 clk = ~clk;

   apt_pair_trig i_apt_pair_trig (.ref_clk_in(clk), .resetn_in(resetn), .addr_in(addr), .wr_data_in(wdata),
      .wr_strobe_in(wr), .rd_strobe_in(rd), .rd_data_out(rdata), .irq_out(irq), .pwm_pri_trig_in(trig[8:1]),
      .pwm_sec_trig_in(trig[19:11]), .pwm_clim_trig_in(trig[27:20]), .pwm_sevt_in(trig[0]),
      .pwm_sec_sevt_in(trig[10]), .tmr1_match_in(trig[9]), .tmr2_match_in(trig[28]), .conv_done_in(done),
      .conv_req_out(req), .conv_chan_out(chan), .conv_pair_out(pair));
   apt_core_model i_apt_core_model (.ref_clk_in(clk), .conv_req_in(req), .conv_pair_in(pair), .lat_in(lat),
      .conv_done_out(done));

   // count requests as the core sees them
   always @(posedge clk) begin
      if (req === 1'b1) begin
         n_req++;
      end
   end

   // one compare, counted; a mismatch is reported at once
   task automatic chk(input logic [15:0] got, input logic [15:0] exp, input string what);
      n_compared++;
      if (got !== exp) begin
         fail_count++;
         $display("unexpected at %0t: %s got %h expected %h", $time, what, got, exp);
      end
   endtask : chk

   // one-cycle write strobe
   task automatic wr_reg(input logic [2:0] a, input logic [15:0] d);
      @(posedge clk);
      addr  <= a;
      wdata <= d;
      wr    <= 1'b1;
      @(posedge clk);
      wr    <= 1'b0;
   endtask : wr_reg

   // read data stand only in the cycle after the strobe
   task automatic rd_reg(input logic [2:0] a, output logic [15:0] d);
      @(posedge clk);
      addr <= a;
      rd   <= 1'b1;
      @(posedge clk);
      rd   <= 1'b0;
      #1 d = rdata;
   endtask : rd_reg

   task automatic idle(input int n);
      repeat (n) @(posedge clk);
   endtask : idle

   // one-cycle trigger pulse on the given inputs
   task automatic pulse(input logic [28:0] bits);
      @(posedge clk);
      trig <= bits;
      @(posedge clk);
      trig <= 29'h0;
   endtask : pulse

   // every word, unmapped one too, reads zero after reset
   task automatic t_reset();
      logic [15:0] d;
      for (int a = 0; a < 8; a++) begin
         rd_reg(3'(a), d);
         chk(d, 16'h0000, "reset value");
      end
   endtask : t_reset

   // software kick of one pair, slow core so awaiting can be read
   task automatic t_kick(input logic [2:0] a, input int sh, input logic [2:0] p, input logic [4:0] c);
      logic [15:0] d;
      int          n0;
      lat <= 8'h14;
      n0 = n_req;
      wr_reg(a, 16'h0001 << sh);
      wr_reg(a, 16'h0021 << sh);
      idle(4);
      rd_reg(a, d);
      chk(d, 16'h0041 << sh, "kick cleared, awaiting set");
      chk(16'(n_req - n0), 16'h0001, "kick request count");
      chk({8'h00, pair, chan}, {8'h00, p, c}, "request target");
      idle(25);
      rd_reg(a, d);
      chk(d, 16'h0001 << sh, "awaiting after done");
      wr_reg(a, 16'h0040 << sh);
      rd_reg(a, d);
      chk(d, 16'h0000, "awaiting not writable");
   endtask : t_kick

   // global kick fires pair 8 only, not pair 9 on its own kick code
   task automatic t_global();
      int n0;
      lat <= 8'h02;
      n0 = n_req;
      wr_reg(apt_pkg::REG_CTRL_EIGHT_NINE, 16'h0102);
      wr_reg(apt_pkg::REG_GLOBAL_KICK, 16'h0001);
      idle(8);
      chk(16'(n_req - n0), 16'h0001, "global request count");
      chk({8'h00, pair, chan}, 16'h0070, "global target");
      wr_reg(apt_pkg::REG_CTRL_EIGHT_NINE, 16'h0000);
   endtask : t_global

   // codes 3 to 31 each answer their own input and no other; code zero answers none
   task automatic t_codes();
      int n0;
      lat <= 8'h02;
      n0 = n_req;
      wr_reg(apt_pkg::REG_CTRL_FOUR, 16'h0000);
      pulse('1);
      idle(8);
      chk(16'(n_req - n0), 16'h0000, "disabled pair fired");
      for (int k = 3; k < 32; k++) begin
         wr_reg(apt_pkg::REG_CTRL_FOUR, 16'(k));
         n0 = n_req;
         pulse(~(29'h1 << (k - 3)));
         idle(8);
         chk(16'(n_req - n0), 16'h0000, "foreign trigger fired");
         pulse(29'h1 << (k - 3));
         idle(8);
         chk(16'(n_req - n0), 16'h0001, "own trigger missed");
      end
   endtask : t_codes

   // second event while awaiting gives no second request
   task automatic t_once();
      int n0;
      lat <= 8'h28;
      wr_reg(apt_pkg::REG_CTRL_FOUR, 16'h000C);
      n0 = n_req;
      pulse(29'h200);
      idle(2);
      pulse(29'h200);
      idle(50);
      chk(16'(n_req - n0), 16'h0001, "requests per awaiting");
   endtask : t_once

   // completion with and without the pair interrupt enable
   task automatic t_irq();
      logic [15:0] d;
      lat <= 8'h02;
      wr_reg(apt_pkg::REG_CTRL_FOUR, 16'h008C);
      pulse(29'h200);
      idle(10);
      rd_reg(apt_pkg::REG_INT_STATUS, d);
      chk(d, 16'h0001, "status on completion");
      chk({15'h0, irq}, 16'h0000, "irq while masked");
      wr_reg(apt_pkg::REG_INT_ENABLE, 16'h0001);
      idle(2);
      chk({15'h0, irq}, 16'h0001, "irq when enabled");
      wr_reg(apt_pkg::REG_INT_CLEAR, 16'h0001);
      idle(2);
      chk({15'h0, irq}, 16'h0000, "irq after clear");
      wr_reg(apt_pkg::REG_CTRL_FOUR, 16'h000C);
      pulse(29'h200);
      idle(10);
      rd_reg(apt_pkg::REG_INT_STATUS, d);
      chk(d, 16'h0000, "status with pair enable off");
      chk({15'h0, irq}, 16'h0000, "irq with pair enable off");
   endtask : t_irq

   // verdict and end of run
   task automatic test_done();
      if (fail_count == 0 && n_compared > 0) begin
         $display("Simulation passed");
      end
      else begin
         $display("Simulation failed");
      end
      $finish;
   endtask : test_done

   // hang guard, far beyond the thousand or so cycles the tests need
   initial begin
      repeat (20000) @(posedge clk);
      fail_count++;
      test_done();
   end

   // main sequence
   initial begin
      repeat (10) @(posedge clk);
      resetn <= 1'b1;
      t_reset();
      t_kick(apt_pkg::REG_CTRL_FOUR, 0, 3'h0, 5'h08);
      t_kick(apt_pkg::REG_CTRL_SIX_SEVEN, 0, 3'h1, 5'h0C);
      t_kick(apt_pkg::REG_CTRL_SIX_SEVEN, 8, 3'h2, 5'h0E);
      t_kick(apt_pkg::REG_CTRL_EIGHT_NINE, 0, 3'h3, 5'h10);
      t_kick(apt_pkg::REG_CTRL_EIGHT_NINE, 8, 3'h4, 5'h12);
      t_global();
      t_codes();
      t_once();
      t_irq();
      test_done();
   end
endmodule : apt_pair_trig_tb
